// ---- core/ic_dev.sv ----
// Interrupt controller device: masks, priorities, flags, combined request.
// Assumes peripheral requests come from logic on clk_i (no synchroniser).
// Function
// R1: Mask byte low enables level sources
// R2: Mask byte mid enables three level sources
// R3: Mask byte high enables edge sources
// R4: Global enable bit gates every interrupt
// R5: One priority bit per source, one high
// R6: Simultaneous requests presented high priority first
// R7: Software leaves priority bits at reset
// R8: Source request sets its flag bit
// R9: Flag bytes read as 24-bit word
// R10: Edge flags cleared by writing one
// R11: Bus frame source is flag bit sixteen
// R12: Level flags follow peripheral status
// R13: Software sets mask before global enable
// R14: All registers reset to zero
// R15: Sixteen level and eight edge sources; the code implements 10 level and 6 edge source bits
// R16: Irq when enabled and unmasked flag set
// R17: Edge set wins over same-cycle clear
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module ic_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ic_pkg::LEVEL_W-1:0] level_req_i,
  input wire logic [ic_pkg::EDGE_W-1:0] edge_req_i,
  output logic [ic_pkg::SRC_W-1:0] flags_o,
  ic_if.dev link
);
  import ic_pkg::*;

  logic [BYTE_W-1:0] mask_low_ff;
  logic [BYTE_W-1:0] mask_mid_ff;
  logic [BYTE_W-1:0] mask_high_ff;
  logic [BYTE_W-1:0] global_ff;
  logic [BYTE_W-1:0] prio_low_ff;
  logic [BYTE_W-1:0] prio_mid_ff;
  logic [BYTE_W-1:0] prio_high_ff;
  logic [LEVEL_W-1:0] level_flag_ff;
  logic [EDGE_W-1:0] edge_flag_ff;
  logic [EDGE_W-1:0] edge_prev_ff;
  logic [BYTE_W-1:0] rdata_ff;
  logic irq_ff;
  logic [ID_W-1:0] id_ff;
  logic high_ff;
  logic [SRC_W-1:0] flag_word;
  logic [SRC_W-1:0] mask_word;
  logic [SRC_W-1:0] prio_word;
  logic [SRC_W-1:0] pending;
  logic [SRC_W-1:0] pending_high;
  logic [EDGE_W-1:0] edge_rise;
  logic [EDGE_W-1:0] edge_clr;
  logic [BYTE_W-1:0] nxt_rdata;
  logic [ID_W-1:0] nxt_id;
  logic nxt_high;
  logic found;

  ////////////////////////////////////////////////////////////////////////////
  // Word views
  assign flag_word = {edge_flag_ff, level_flag_ff}; // R9 R15
  assign mask_word = {mask_high_ff, mask_mid_ff, mask_low_ff};
  assign prio_word = {prio_high_ff, prio_mid_ff, prio_low_ff};
  assign pending = flag_word & mask_word;
  assign pending_high = pending & prio_word;
  assign flags_o = flag_word;

  ////////////////////////////////////////////////////////////////////////////
  // Mask registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_low_ff <= RESET_BYTE; // R14
      mask_mid_ff <= RESET_BYTE;
      mask_high_ff <= RESET_BYTE;
    end else if (ce_i && link.reg_we) begin
      if (link.reg_addr == ADDR_MASK_LOW) begin
        mask_low_ff <= link.reg_wdata & VALID_LOW; // R1
      end
      if (link.reg_addr == ADDR_MASK_MID) begin
        mask_mid_ff <= link.reg_wdata & VALID_MID; // R2
      end
      if (link.reg_addr == ADDR_MASK_HIGH) begin
        mask_high_ff <= link.reg_wdata & VALID_HIGH; // R3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_ff <= RESET_BYTE; // R14
    end else if (ce_i && link.reg_we && link.reg_addr == ADDR_GLOBAL_EN) begin
      global_ff <= link.reg_wdata & VALID_GLOBAL; // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority registers, kept writable though software should not touch them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_low_ff <= RESET_BYTE; // R14
      prio_mid_ff <= RESET_BYTE;
      prio_high_ff <= RESET_BYTE;
    end else if (ce_i && link.reg_we) begin
      if (link.reg_addr == ADDR_PRIO_LOW) begin
        prio_low_ff <= link.reg_wdata & VALID_LOW; // R5
      end
      if (link.reg_addr == ADDR_PRIO_MID) begin
        prio_mid_ff <= link.reg_wdata & VALID_MID; // R5
      end
      if (link.reg_addr == ADDR_PRIO_HIGH) begin
        prio_high_ff <= link.reg_wdata & VALID_HIGH; // R5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level flags mirror the peripheral status; cleared only at the source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_flag_ff <= '0; // R14
    end else if (ce_i) begin
      level_flag_ff <= level_req_i & {VALID_MID, VALID_LOW}; // R8 R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge flags are sticky
  assign edge_rise = edge_req_i & ~edge_prev_ff & VALID_HIGH; // R17
  assign edge_clr = (link.reg_we && link.reg_addr == ADDR_FLAGS_HIGH) ?
                    link.reg_wdata : '0; // R10 R11

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_prev_ff <= '0;
    end else if (ce_i) begin
      edge_prev_ff <= edge_req_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_flag_ff <= '0; // R14
    end else if (ce_i) begin
      // Set after clear so a new edge is never lost
      edge_flag_ff <= (edge_flag_ff & ~edge_clr) | edge_rise; // R8 R10 R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, data valid the cycle after the read strobe
  always_comb begin
    unique case (link.reg_addr)
      ADDR_MASK_LOW: nxt_rdata = mask_low_ff;
      ADDR_MASK_MID: nxt_rdata = mask_mid_ff;
      ADDR_MASK_HIGH: nxt_rdata = mask_high_ff;
      ADDR_GLOBAL_EN: nxt_rdata = global_ff;
      ADDR_PRIO_LOW: nxt_rdata = prio_low_ff;
      ADDR_PRIO_MID: nxt_rdata = prio_mid_ff;
      ADDR_PRIO_HIGH: nxt_rdata = prio_high_ff;
      ADDR_FLAGS_LOW: nxt_rdata = flag_word[BYTE_W-1:0]; // R9
      ADDR_FLAGS_MID: nxt_rdata = flag_word[2*BYTE_W-1:BYTE_W]; // R9
      ADDR_FLAGS_HIGH: nxt_rdata = flag_word[SRC_W-1:2*BYTE_W]; // R9
      default: nxt_rdata = RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= RESET_BYTE;
    end else if (ce_i && link.reg_re) begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection: lowest index among high-priority, else among all
  always_comb begin
    nxt_id = '0;
    nxt_high = 1'b0;
    found = 1'b0;
    for (int i = 0; i < SRC_W; i++) begin
      if (!found && pending_high[i]) begin
        nxt_id = ID_W'(i); // R6
        nxt_high = 1'b1;
        found = 1'b1;
      end
    end
    for (int i = 0; i < SRC_W; i++) begin
      if (!found && pending[i]) begin
        nxt_id = ID_W'(i); // R6
        found = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combined request to the processor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
      id_ff <= '0;
      high_ff <= 1'b0;
    end else if (ce_i) begin
      irq_ff <= global_ff[GLOBAL_EN_BIT] && (|pending); // R4 R16
      id_ff <= nxt_id;
      high_ff <= nxt_high;
    end
  end

  assign link.reg_rdata = rdata_ff;
  assign link.irq = irq_ff;
  assign link.irq_id = id_ff;
  assign link.irq_high = high_ff;
endmodule

// ---- core/ic_pkg.sv ----
// Package for the interrupt controller: register map, field layouts, widths.
// Assumes one system clock shared by both ends of the register link.
package ic_pkg;
  localparam int ADDR_W = 12;
  localparam int BYTE_W = 8;
  localparam int LEVEL_W = 16;
  localparam int EDGE_W = 8;
  localparam int SRC_W = 24;
  localparam int ID_W = 5;

  // Device register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_MASK_LOW = 12'h640;
  localparam logic [ADDR_W-1:0] ADDR_MASK_MID = 12'h641;
  localparam logic [ADDR_W-1:0] ADDR_MASK_HIGH = 12'h642;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL_EN = 12'h643;
  localparam logic [ADDR_W-1:0] ADDR_PRIO_LOW = 12'h644;
  localparam logic [ADDR_W-1:0] ADDR_PRIO_MID = 12'h645;
  localparam logic [ADDR_W-1:0] ADDR_PRIO_HIGH = 12'h646;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS_LOW = 12'h648;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS_MID = 12'h649;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS_HIGH = 12'h64A;

  // Implemented bits of each byte; reserved bits read zero
  localparam logic [BYTE_W-1:0] VALID_LOW = 8'hF7;
  localparam logic [BYTE_W-1:0] VALID_MID = 8'hE0;
  localparam logic [BYTE_W-1:0] VALID_HIGH = 8'h7D;
  localparam logic [BYTE_W-1:0] VALID_GLOBAL = 8'h01;
  localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;
  localparam int GLOBAL_EN_BIT = 0;

  // Controller registers on Wishbone, byte offsets
  localparam int WB_ADR_W = 8;
  localparam logic [WB_ADR_W-1:0] WB_CMD_ADDR = 8'h00;
  localparam logic [WB_ADR_W-1:0] WB_CMD_DATA = 8'h04;
  localparam logic [WB_ADR_W-1:0] WB_CTRL = 8'h08;
  localparam logic [WB_ADR_W-1:0] WB_STATUS = 8'h0C;
  localparam logic [WB_ADR_W-1:0] WB_RDATA = 8'h10;
  localparam logic [WB_ADR_W-1:0] WB_IRQ_STAT = 8'h14;
  localparam logic [WB_ADR_W-1:0] WB_IRQ_MASK = 8'h18;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_IRQ_BIT = 1;
  localparam int ST_ID_LSB = 8;
  localparam int ST_HIGH_BIT = 13;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_IRQ_BIT = 1;
  localparam int EV_W = 2;

  typedef enum logic [1:0] {
    IC_IDLE = 2'b00,
    IC_ISSUE = 2'b01,
    IC_CAPTURE = 2'b10
  } ic_state_t;
endpackage

// ---- core/ic_if.sv ----
// Link between the interrupt controller device and the processor-side end.
// Assumes both ends share clk_i; strobes are one-cycle pulses.
`timescale 1ns/1ps
interface ic_if;
  import ic_pkg::*;
  logic [ADDR_W-1:0] reg_addr;
  logic [BYTE_W-1:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [BYTE_W-1:0] reg_rdata;
  logic irq;
  logic [ID_W-1:0] irq_id;
  logic irq_high;

  modport dev (
    input reg_addr,
    input reg_wdata,
    input reg_we,
    input reg_re,
    output reg_rdata,
    output irq,
    output irq_id,
    output irq_high
  );

  modport host (
    output reg_addr,
    output reg_wdata,
    output reg_we,
    output reg_re,
    input reg_rdata,
    input irq,
    input irq_id,
    input irq_high
  );
endinterface

// ---- core/ic_host.sv ----
// Processor-side end: Wishbone slave that runs byte accesses on the link.
// Assumes software follows the mask-then-enable order and keeps priorities.
`timescale 1ns/1ps
module ic_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ic_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  ic_if.host link
);
  import ic_pkg::*;

  ic_state_t state_ff;
  ic_state_t nxt_state;
  logic [ADDR_W-1:0] cmd_addr_ff;
  logic [BYTE_W-1:0] cmd_data_ff;
  logic cmd_write_ff;
  logic [BYTE_W-1:0] rdata_ff;
  logic [EV_W-1:0] ev_stat_ff;
  logic [EV_W-1:0] ev_mask_ff;
  logic irq_prev_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic wb_req;
  logic wb_wr;
  logic start;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one-wait-state ack
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_wr = wb_req && wb_we_i;
  // Start while busy is dropped; software polls busy first
  assign start = wb_wr && wb_adr_i == WB_CTRL && wb_sel_i[0] &&
                 wb_dat_i[CTRL_START_BIT] && state_ff == IC_IDLE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_addr_ff <= '0;
      cmd_data_ff <= '0;
    end else if (ce_i && wb_wr) begin
      if (wb_adr_i == WB_CMD_ADDR && wb_sel_i[0]) begin
        cmd_addr_ff[BYTE_W-1:0] <= wb_dat_i[BYTE_W-1:0];
      end
      if (wb_adr_i == WB_CMD_ADDR && wb_sel_i[1]) begin
        cmd_addr_ff[ADDR_W-1:BYTE_W] <= wb_dat_i[ADDR_W-1:BYTE_W];
      end
      if (wb_adr_i == WB_CMD_DATA && wb_sel_i[0]) begin
        cmd_data_ff <= wb_dat_i[BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_write_ff <= 1'b0;
    end else if (ce_i && start) begin
      cmd_write_ff <= wb_dat_i[CTRL_WRITE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link access sequencer
  always_comb begin
    unique case (state_ff)
      IC_IDLE: nxt_state = start ? IC_ISSUE : IC_IDLE;
      IC_ISSUE: nxt_state = cmd_write_ff ? IC_IDLE : IC_CAPTURE;
      IC_CAPTURE: nxt_state = IC_IDLE;
      default: nxt_state = IC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= IC_IDLE;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
    end else if (ce_i && state_ff == IC_CAPTURE) begin
      rdata_ff <= link.reg_rdata; // R9
    end
  end

  assign link.reg_addr = cmd_addr_ff;
  assign link.reg_wdata = cmd_data_ff;
  assign link.reg_we = state_ff == IC_ISSUE && cmd_write_ff;
  assign link.reg_re = state_ff == IC_ISSUE && !cmd_write_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Events: access done, device request rising
  assign ev_set[EV_DONE_BIT] = (state_ff == IC_ISSUE && cmd_write_ff) ||
                               state_ff == IC_CAPTURE;
  assign ev_set[EV_IRQ_BIT] = link.irq && !irq_prev_ff;
  assign ev_clr = (wb_wr && wb_adr_i == WB_IRQ_STAT && wb_sel_i[0]) ?
                  wb_dat_i[EV_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_prev_ff <= 1'b0;
      ev_stat_ff <= '0;
    end else if (ce_i) begin
      irq_prev_ff <= link.irq;
      // Set wins over a same-cycle clear
      ev_stat_ff <= (ev_stat_ff & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_mask_ff <= '0;
    end else if (ce_i && wb_wr && wb_adr_i == WB_IRQ_MASK && wb_sel_i[0]) begin
      ev_mask_ff <= wb_dat_i[EV_W-1:0];
    end
  end

  assign irq_o = |(ev_stat_ff & ev_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    status_word = '0;
    status_word[ST_BUSY_BIT] = state_ff != IC_IDLE;
    status_word[ST_IRQ_BIT] = link.irq;
    status_word[ST_ID_LSB +: ID_W] = link.irq_id; // R6
    status_word[ST_HIGH_BIT] = link.irq_high;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= '0;
    end else if (ce_i && wb_req) begin
      unique case (wb_adr_i)
        WB_CMD_ADDR: dat_ff <= 32'(cmd_addr_ff);
        WB_CMD_DATA: dat_ff <= 32'(cmd_data_ff);
        WB_STATUS: dat_ff <= status_word;
        WB_RDATA: dat_ff <= 32'(rdata_ff);
        WB_IRQ_STAT: dat_ff <= 32'(ev_stat_ff);
        WB_IRQ_MASK: dat_ff <= 32'(ev_mask_ff);
        default: dat_ff <= '0;
      endcase
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
endmodule

// ---- verification/ic_props.sv ----
// Checker for the device side of the register link.
// Assumes ce_i is held high, so every edge out of reset counts.
`timescale 1ns/1ps
module ic_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ic_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ic_pkg::BYTE_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [ic_pkg::BYTE_W-1:0] reg_rdata,
  input wire logic irq,
  input wire logic [ic_pkg::ID_W-1:0] irq_id,
  input wire logic irq_high
);
  import ic_pkg::*;
  logic [SRC_W-1:0] mask_ff;
  logic [SRC_W-1:0] prio_ff;
  logic [SRC_W-1:0] mask_d_ff;
  logic [SRC_W-1:0] prio_d_ff;
  logic en_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow copies, rebuilt from link writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= '0;
    end else if (reg_we) begin
      if (reg_addr == ADDR_MASK_LOW) mask_ff[7:0] <= reg_wdata & VALID_LOW;
      if (reg_addr == ADDR_MASK_MID) mask_ff[15:8] <= reg_wdata & VALID_MID;
      if (reg_addr == ADDR_MASK_HIGH) mask_ff[23:16] <= reg_wdata & VALID_HIGH;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_ff <= '0;
    end else if (reg_we) begin
      if (reg_addr == ADDR_PRIO_LOW) prio_ff[7:0] <= reg_wdata & VALID_LOW;
      if (reg_addr == ADDR_PRIO_MID) prio_ff[15:8] <= reg_wdata & VALID_MID;
      if (reg_addr == ADDR_PRIO_HIGH) prio_ff[23:16] <= reg_wdata & VALID_HIGH;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff <= 1'b0;
    end else if (reg_we && reg_addr == ADDR_GLOBAL_EN) begin
      en_ff <= reg_wdata[GLOBAL_EN_BIT];
    end
  end
  // irq and irq_id lag the registers by one cycle
  always_ff @(posedge clk_i) begin
    mask_d_ff <= mask_ff;
    prio_d_ff <= prio_ff;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_read(logic [11:0] a);
    reg_re && reg_addr == a;
  endsequence
  property p_readback(logic [11:0] a, logic [7:0] v);
    s_read(a) |=> reg_rdata == $past(v);
  endproperty
  a_mask_low_read: assert property (p_readback(ADDR_MASK_LOW, mask_ff[7:0]))
    else $error("mask low readback wrong");
  a_mask_mid_read: assert property (p_readback(ADDR_MASK_MID, mask_ff[15:8]))
    else $error("mask mid readback wrong");
  a_mask_high_read: assert property (p_readback(ADDR_MASK_HIGH, mask_ff[23:16]))
    else $error("mask high readback wrong");
  a_enable_read: assert property (p_readback(ADDR_GLOBAL_EN, {7'h00, en_ff}))
    else $error("enable readback wrong");
  a_prio_high_read: assert property (p_readback(ADDR_PRIO_HIGH, prio_ff[23:16]))
    else $error("priority high readback wrong");
  a_unmapped_zero: assert property (s_read(12'h647) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_enable_gates_irq: assert property (irq |-> $past(en_ff))
    else $error("irq while globally disabled");
  a_irq_unmasked: assert property (irq |-> mask_d_ff[irq_id])
    else $error("irq from masked source");
  a_high_prio_sel: assert property (irq && irq_high |-> prio_d_ff[irq_id])
    else $error("high flag on low source");
  a_reset_quiet: assert property ($fell(rst_i) |-> !irq && reg_rdata == 8'h00)
    else $error("outputs not clear after reset");
  a_strobe_single: assert property (reg_re |=> !reg_re && !reg_we)
    else $error("read strobe longer than one cycle");
  c_high_irq: cover property (irq && irq_high);
endmodule

// ---- verification/tb_irq_mask_priority_flags.sv ----
// Testbench: both ends joined by the link, driven over Wishbone.
// Assumes the host ends each access with busy low, and each read with RDATA updated.
`timescale 1ns/1ps
module tb_irq_mask_priority_flags;
  import ic_pkg::*;
  localparam logic [11:0] RW_ADDR [7] = '{ADDR_MASK_LOW, ADDR_MASK_MID, ADDR_MASK_HIGH,
    ADDR_GLOBAL_EN, ADDR_PRIO_LOW, ADDR_PRIO_MID, ADDR_PRIO_HIGH};
  localparam logic [7:0] RW_VALID [7] = '{VALID_LOW, VALID_MID, VALID_HIGH, VALID_GLOBAL,
    VALID_LOW, VALID_MID, VALID_HIGH};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic irq_o;
  logic [15:0] level_req = 16'h0000;
  logic [7:0] edge_req = 8'h00;
  logic [23:0] flags;
  logic [7:0] m_reg [7] = '{default: 8'h00};
  logic [7:0] m_edge = 8'h00;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 64;
  always #10 clk_i = ~clk_i;
  ic_if ic_if_i ();
  ic_dev ic_dev_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .level_req_i(level_req),
    .edge_req_i(edge_req), .flags_o(flags), .link(ic_if_i));
  ic_host ic_host_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq_o), .link(ic_if_i));
  ic_props ic_props_i (.clk_i(clk_i), .rst_i(rst_i), .reg_addr(ic_if_i.reg_addr),
    .reg_wdata(ic_if_i.reg_wdata), .reg_we(ic_if_i.reg_we), .reg_re(ic_if_i.reg_re),
    .reg_rdata(ic_if_i.reg_rdata), .irq(ic_if_i.irq), .irq_id(ic_if_i.irq_id),
    .irq_high(ic_if_i.irq_high));
  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Bounded wait: a missing ack ends in the timeout, not a hang
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = wb_rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task dev(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    int n;
    wb(1'b1, WB_CMD_ADDR, {20'h0, a}, r);
    wb(1'b1, WB_CMD_DATA, {24'h0, d}, r);
    wb(1'b1, WB_CTRL, {30'h0, w, 1'b1}, r);
    n = 0;
    r = 32'h1;
    while (r[ST_BUSY_BIT] !== 1'b0 && n < 20) begin
      wb(1'b0, WB_STATUS, 32'h0, r);
      n++;
    end
    chk("busy_clear", 32'h0, {31'h0, r[ST_BUSY_BIT]});
    wb(1'b0, WB_RDATA, 32'h0, r);
    q = r[7:0];
  endtask
  task wr(input int i, input logic [7:0] v);
    logic [7:0] q;
    dev(1'b1, RW_ADDR[i], v, q);
    m_reg[i] = v & RW_VALID[i];
  endtask
  // Expected irq and selection from the model registers
  task chk_status;
    logic [31:0] r;
    logic [23:0] pend;
    logic [23:0] hp;
    int id;
    logic hi;
    pend = {m_edge, level_req & 16'hE0F7} & {m_reg[2], m_reg[1], m_reg[0]};
    hp = pend & {m_reg[6], m_reg[5], m_reg[4]};
    id = 0;
    hi = 1'b0;
    for (int i = 23; i >= 0; i--) if (pend[i]) id = i;
    for (int i = 23; i >= 0; i--) if (hp[i]) {hi, id} = {1'b1, i};
    wb(1'b0, WB_STATUS, 32'h0, r);
    chk("dev_irq", {31'h0, m_reg[3][0] & (|pend)}, {31'h0, r[ST_IRQ_BIT]});
    if (|pend) chk("irq_sel", {hi, 5'(id)}, {r[ST_HIGH_BIT], r[ST_ID_LSB+:5]});
  endtask
  task chk_flags;
    logic [7:0] q;
    chk("flags_o", {m_edge, level_req & 16'hE0F7}, flags);
    for (int i = 0; i < 3; i++) begin
      dev(1'b0, ADDR_FLAGS_LOW + 12'(i), 8'h00, q);
      chk("flags_byte", {m_edge, level_req & 16'hE0F7} >> (8 * i) & 8'hFF, q);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [7:0] q;
    logic [7:0] p;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      dev(1'b0, RW_ADDR[i], 8'h00, q);
      chk("reset_reg", 32'h0, q);
    end
    dev(1'b0, 12'h647, 8'h00, q);
    chk("unmapped", 32'h0, q);
    chk_flags();
    wb(1'b0, 8'h1C, 32'h0, r);
    chk("wb_unmapped", 32'h0, r);
    // Host interrupt: done event is pending but masked
    chk("irq_o_masked", 32'h0, irq_o);
    wb(1'b1, WB_IRQ_MASK, 32'h1, r);
    chk("irq_o_raised", 32'h1, irq_o);
    wb(1'b1, WB_IRQ_STAT, 32'h3, r);
    wb(1'b1, WB_IRQ_MASK, 32'h0, r);
    chk("irq_o_cleared", 32'h0, irq_o);
    // Random config readback; reserved bits must drop
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 7; i++) begin
        wr(i, 8'($random(seed)));
        dev(1'b0, RW_ADDR[i], 8'h00, q);
        chk("rw_reg", m_reg[i], q);
      end
    end
    dev(1'b1, 12'h647, 8'hFF, q);
    dev(1'b1, ADDR_FLAGS_LOW, 8'hFF, q);
    chk_flags();
    // Level sources under random masks and priorities, enable alternating off and on
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      level_req <= 16'($random(seed));
      wr(0, 8'($random(seed)));
      wr(1, 8'($random(seed)));
      wr(4, 8'($random(seed)));
      wr(5, 8'($random(seed)));
      wr(3, 8'(k % 2));
      chk_flags();
      chk_status();
    end
    // Priorities back to reset values before the edge sources
    wr(4, 8'h00);
    wr(5, 8'h00);
    wr(6, 8'h00);
    // Edge sources; bus-frame line held high across its clear
    @(posedge clk_i);
    level_req <= 16'h0000;
    wr(2, 8'hFF);
    p = 8'($random(seed)) | 8'h01;
    @(posedge clk_i);
    edge_req <= p;
    @(posedge clk_i);
    edge_req <= 8'h01;
    m_edge = p & 8'h7D;
    repeat (2) @(posedge clk_i);
    chk_flags();
    chk_status();
    dev(1'b1, ADDR_FLAGS_HIGH, 8'h01, q);
    m_edge = m_edge & 8'hFE;
    chk("bus_frame_clr", {m_edge, 16'h0}, flags);
    @(posedge clk_i);
    edge_req <= 8'h00;
    dev(1'b1, ADDR_FLAGS_HIGH, 8'hFF, q);
    m_edge = 8'h00;
    chk_flags();
    // Device irq event through the host, high priority timer zero
    wr(3, 8'h00);
    wb(1'b1, WB_IRQ_STAT, 32'h3, r);
    wb(1'b1, WB_IRQ_MASK, 32'h2, r);
    @(posedge clk_i);
    level_req <= 16'h0001;
    wr(0, 8'h01);
    wr(4, 8'h01);
    wr(3, 8'h01);
    chk_status();
    chk("irq_o_event", 32'h1, irq_o);
    @(posedge clk_i);
    level_req <= 16'h0000;
    repeat (3) @(posedge clk_i);
    chk_flags();
    chk("irq_o_sticky", 32'h1, irq_o);
    wb(1'b1, WB_IRQ_STAT, 32'h2, r);
    chk("irq_o_w1c", 32'h0, irq_o);
    complete_run();
  end
endmodule
